// ---- hw/dpb_pkg.sv ----
/*
 * Package of the port-1 DMA bridge: constants, state types and the
 * control record of the bridge; its write buffer uses the constants only.
 * Assumes one 20 MHz core clock and a synchronous active-low reset.
 */
// Operation
// - Register write: quadword carries one longword update
// - Acknowledge only own address without parity error
// - Lower mask nonzero picks low longword
// - Port reads to I/O space end in error
// - Prefetch enabled fetches the longer table length
// - Unlocked read, same hexaword and requested longwords valid: serve from buffer
// - Delivered longword loses its valid bit
// - Miss forwards the read and invalidates buffer
// - Same hexaword during prefetch waits for it
// - Read matching pending write hexaword stalls
// - Locked read flushes pending writes first
// - Reads win over posted writes
// - Read address goes out only after grant
// - Deliver data on arrival, keep unrequested prefetch
// - Writes, locks, own I/O drop prefetch data
// - Port writes to I/O space end in error
// - Short writes quadword, long writes octaword
// - Buffered write invalidates, arbitrates, then issues
package dpb_pkg;

  // ****************************************************************
  // Register space
  // ****************************************************************
  localparam logic [31:0] DPB_REG_BASE = 32'h2000_0000;
  localparam int unsigned DPB_REG_LWORDS = 2;
  localparam int unsigned DPB_CTRL_IDX = 0;
  localparam int unsigned DPB_PF_EN_BIT = 0;
  localparam logic [31:0] DPB_CTRL_RST = 32'h0000_0000;

  // ****************************************************************
  // System bus commands and lengths
  // ****************************************************************
  localparam logic [2:0] DPB_CMD_WRITE = 3'h2;
  localparam logic [2:0] DPB_CMD_WRITE_DISOWN = 3'h3;
  localparam logic [1:0] DPB_MCMD_READ = 2'h1;
  localparam logic [1:0] DPB_MCMD_WRITE = 2'h2;
  localparam logic [2:0] DPB_SLEN_QW = 3'h1;
  localparam logic [2:0] DPB_SLEN_OCT = 3'h2;
  localparam logic [2:0] DPB_SLEN_HEX = 3'h4;

  // ****************************************************************
  // Port lengths and write buffer
  // ****************************************************************
  localparam logic [1:0] DPB_LEN_LW = 2'h0;
  localparam logic [1:0] DPB_LEN_QW = 2'h1;
  localparam logic [1:0] DPB_LEN_HW = 2'h2;
  localparam logic [1:0] DPB_LEN_OW = 2'h3;
  localparam int unsigned DPB_WBUF_DEPTH = 32;
  localparam int unsigned DPB_WBUF_WIDTH = 36;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [1:0] {DPB_P_IDLE, DPB_P_CHECK, DPB_P_SERVE} dpb_port_e;
  typedef enum logic [2:0] {DPB_M_IDLE, DPB_M_REQ, DPB_M_WDATA} dpb_mst_e;

  typedef struct packed {
    dpb_port_e ps;
    dpb_mst_e ms;
    logic [31:0] l_addr;
    logic [1:0] l_len;
    logic l_wr;
    logic l_lock;
    logic l_io;
    logic [7:0] need;
    logic [26:0] prev_hex;
    logic prev_v;
    logic [7:0] rb_v;
    logic [7:0] keep;
    logic fetch;
    logic [1:0] f_q;
    logic [2:0] f_n;
    logic [2:0] f_cnt;
    logic rfwd;
    logic wpend;
    logic [31:0] w_addr;
    logic [1:0] w_len;
    logic [2:0] w_slot;
    logic [31:0] w_lo;
    logic [3:0] w_lom;
    logic m_rd;
    logic req_rdy;
    logic rv;
    logic [31:0] rdata;
    logic done;
    logic err_n;
    logic sreq;
    logic mvalid;
    logic [1:0] mcmd;
    logic [31:0] maddr;
    logic [2:0] mlen;
    logic mlock;
    logic [63:0] mdata;
    logic [7:0] mmask;
    logic mdv;
  } dpb_st_s;

endpackage

// ---- hw/dpb_wbuf.sv ----
/*
 * Write buffer FIFO of the port-1 DMA bridge, width and depth set by
 * parameters. Assumes both sides on the core clock; depth a power of two.
 */
`timescale 1ns/1ps
module dpb_wbuf
  import dpb_pkg::*;
#(
  parameter int unsigned WIDTH = DPB_WBUF_WIDTH,
  parameter int unsigned DEPTH = DPB_WBUF_DEPTH,
  localparam int unsigned AW = $clog2(DEPTH),
  localparam int unsigned LVW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [LVW-1:0] level_out
);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("dpb_wbuf: DEPTH must be a power of two of at least 4");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd;
  logic [AW-1:0] wr;
  logic [AW-1:0] next_rd;
  logic [AW-1:0] next_wr;
  logic [LVW-1:0] next_level;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd];

  always_comb begin
    next_rd = pop ? rd + AW'(1) : rd;
    next_wr = push ? wr + AW'(1) : wr;
    next_level = level_out + LVW'(push) - LVW'(pop);
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rd <= '0;
      wr <= '0;
      level_out <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      rd <= next_rd;
      wr <= next_wr;
      level_out <= next_level;
      in_ready_out <= next_level != LVW'(DEPTH);
      out_valid_out <= next_level != '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr] <= in_data_in;
    end
  end

endmodule // dpb_wbuf

// ---- hw/dpb_bridge.sv ----
/*
 * Port-1 DMA bridge: system-bus register slave, prefetching read buffer
 * for port DMA reads and a posted write buffer for port DMA writes.
 * Assumes all requesters run on core_clk_in and hold requests until ready.
 */
`timescale 1ns/1ps
module dpb_bridge
  import dpb_pkg::*;
#(
  parameter int unsigned WBUF_DEPTH = DPB_WBUF_DEPTH,
  parameter logic [31:0] REG_BASE = DPB_REG_BASE
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // System bus slave
  input wire logic sys_cmd_valid_in,
  input wire logic [2:0] sys_cmd_in,
  input wire logic [31:0] sys_addr_in,
  input wire logic [7:0] sys_mask_in,
  input wire logic [63:0] sys_data_in,
  input wire logic sys_parity_err_in,
  output logic sys_ack_out,
  output logic prefetch_en_out,
  // System bus master
  output logic sys_req_out,
  input wire logic sys_gnt_in,
  output logic sys_mvalid_out,
  output logic [1:0] sys_mcmd_out,
  output logic [31:0] sys_maddr_out,
  output logic [2:0] sys_mlen_out,
  output logic sys_mlock_out,
  output logic sys_mdvalid_out,
  output logic [63:0] sys_mdata_out,
  output logic [7:0] sys_mmask_out,
  input wire logic sys_rvalid_in,
  input wire logic [63:0] sys_rdata_in,
  // Port bus requests
  input wire logic port1_req_valid_in,
  output logic port1_req_ready_out,
  input wire logic port1_req_write_in,
  input wire logic port1_req_lock_in,
  input wire logic port1_req_io_in,
  input wire logic [31:0] port1_addr_in,
  input wire logic [1:0] port1_len_in,
  input wire logic port1_io_txn_in,
  // Port bus write data
  input wire logic port1_wvalid_in,
  output logic port1_wready_out,
  input wire logic [31:0] port1_wdata_in,
  input wire logic [3:0] port1_wmask_in,
  // Port bus answers
  output logic port1_rvalid_out,
  output logic [31:0] port1_rdata_out,
  output logic port1_done_out,
  output logic port1_error_n_out
);

  localparam int unsigned LVW = $clog2(WBUF_DEPTH + 1);

  if (WBUF_DEPTH < 4) begin : g_bad_depth
    $error("dpb_bridge: WBUF_DEPTH must hold an octaword");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // length decode
  function automatic logic [7:0] need_mask(input logic [2:0] lw, input logic [1:0] len);
    logic [3:0] ones;
    ones = 4'hf >> (2'd3 - len);
    return 8'(ones) << lw;
  endfunction

  function automatic logic [2:0] fetch_qw(input logic [1:0] len, input logic pf);
    case (len)
      DPB_LEN_LW: return DPB_SLEN_QW;
      DPB_LEN_QW: return pf ? DPB_SLEN_OCT : DPB_SLEN_QW;
      DPB_LEN_HW: return DPB_SLEN_OCT;
      default: return pf ? DPB_SLEN_HEX : DPB_SLEN_OCT;
    endcase
  endfunction

  // ****************************************************************
  // Register slave
  // ****************************************************************
  logic s_v;
  logic s_perr;
  logic [2:0] s_cmd;
  logic [31:0] s_addr;
  logic [7:0] s_mask;
  logic [63:0] s_data;
  logic [31:0] csr [DPB_REG_LWORDS];
  logic [31:0] next_csr [DPB_REG_LWORDS];
  logic next_ack;

  always_comb begin
    logic up;
    up = s_mask[3:0] == 4'h0;
    next_csr = csr;
    next_ack = s_v && !s_perr && (s_addr[31:3] == REG_BASE[31:3]) &&
      (s_cmd == DPB_CMD_WRITE || s_cmd == DPB_CMD_WRITE_DISOWN);
    if (next_ack) begin
      next_csr[up] = up ? s_data[63:32] : s_data[31:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    s_cmd <= sys_cmd_in;
    s_addr <= sys_addr_in;
    s_mask <= sys_mask_in;
    s_data <= sys_data_in;
    s_perr <= sys_parity_err_in;
    if (!nrst_in) begin
      s_v <= 1'b0;
      sys_ack_out <= 1'b0;
      prefetch_en_out <= 1'b0;
      csr <= '{default: DPB_CTRL_RST};
    end else begin
      s_v <= sys_cmd_valid_in;
      sys_ack_out <= next_ack;
      prefetch_en_out <= next_csr[DPB_CTRL_IDX][DPB_PF_EN_BIT];
      csr <= next_csr;
    end
  end

  // ****************************************************************
  // Write buffer
  // ****************************************************************
  logic wf_valid;
  logic wf_pop;
  logic [35:0] wf_data;
  logic [LVW-1:0] wf_level;

  dpb_wbuf #(.WIDTH(DPB_WBUF_WIDTH), .DEPTH(WBUF_DEPTH)) u_wbuf (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(port1_wvalid_in),
    .in_ready_out(port1_wready_out),
    .in_data_in({port1_wmask_in, port1_wdata_in}),
    .out_valid_out(wf_valid),
    .out_ready_in(wf_pop),
    .out_data_out(wf_data),
    .level_out(wf_level)
  );

  // ****************************************************************
  // Port and master control
  // ****************************************************************
  dpb_st_s st;
  dpb_st_s next_st;
  logic [31:0] rbuf [8];
  logic [1:0] fill_q;
  logic filling;

  assign filling = sys_rvalid_in && st.fetch;
  assign fill_q = (st.f_q & ~2'(st.f_n - 3'd1)) |
    ((st.f_q + st.f_cnt[1:0]) & 2'(st.f_n - 3'd1));

  always_comb begin
    logic [7:0] nm;
    logic [7:0] wn;
    logic [7:0] blk;
    logic [2:0] idx;
    logic [2:0] wb;
    logic [2:0] lwi;
    logic [2:0] nlw;
    logic hit;
    logic whit;
    logic inval;
    logic ins;
    logic [31:0] d;
    logic [3:0] m;
    nm = need_mask(st.l_addr[4:2], st.l_len);
    wn = need_mask(st.w_addr[4:2], st.w_len);
    blk = 8'((9'h1 << {st.f_n, 1'b0}) - 9'h1) << {st.f_q & ~2'(st.f_n - 3'd1), 1'b0};
    idx = 3'd0;
    wb = (st.w_len < DPB_LEN_HW) ? {st.w_addr[4:3], 1'b0} : {st.w_addr[4], 2'b00};
    lwi = wb + st.w_slot;
    nlw = {1'b0, st.w_len} + 3'd1;
    // same hexaword with every requested longword valid
    hit = st.prev_v && (st.l_addr[31:5] == st.prev_hex) && ((st.rb_v & nm) == nm);
    whit = st.wpend && (st.w_addr[31:5] == st.l_addr[31:5]);
    inval = port1_io_txn_in;
    ins = wn[lwi];
    d = ins ? wf_data[31:0] : 32'h0000_0000;
    m = ins ? wf_data[35:32] : 4'h0;
    wf_pop = 1'b0;
    next_st = st;
    next_st.rv = 1'b0;
    next_st.done = 1'b0;
    next_st.err_n = 1'b1;
    next_st.mvalid = 1'b0;
    next_st.mdv = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (st.need[i]) begin
        idx = 3'(i);
      end
    end

    case (st.ps)
      DPB_P_IDLE: begin
        if (port1_req_valid_in && st.req_rdy) begin
          next_st.l_addr = port1_addr_in;
          next_st.l_len = port1_len_in;
          next_st.l_wr = port1_req_write_in;
          next_st.l_lock = port1_req_lock_in;
          next_st.l_io = port1_req_io_in;
          next_st.ps = DPB_P_CHECK;
        end
      end
      DPB_P_CHECK: begin
        if (st.l_io) begin
          next_st.err_n = 1'b0;
          next_st.done = 1'b1;
          next_st.ps = DPB_P_IDLE;
        end else if (st.l_wr) begin
          // latch posted write and drop prefetch
          if (!st.wpend) begin
            next_st.wpend = 1'b1;
            next_st.w_addr = st.l_addr;
            next_st.w_len = st.l_len;
            next_st.done = 1'b1;
            next_st.ps = DPB_P_IDLE;
            inval = 1'b1;
          end
        end else if (whit || (st.l_lock && st.wpend)) begin
          // wait for pending write to finish
          next_st.ps = DPB_P_CHECK;
        end else if (hit && !st.l_lock) begin
          next_st.need = nm;
          next_st.ps = DPB_P_SERVE;
        end else if (!st.fetch) begin
          // forward a miss with its fetch length
          next_st.rb_v = 8'h00;
          next_st.prev_hex = st.l_addr[31:5];
          next_st.prev_v = 1'b1;
          next_st.f_q = st.l_addr[4:3];
          next_st.f_n = fetch_qw(st.l_len, prefetch_en_out);
          next_st.keep = (prefetch_en_out && !st.l_lock) ? 8'hff : nm;
          next_st.need = nm;
          next_st.rfwd = 1'b1;
          next_st.ps = DPB_P_SERVE;
        end
        // otherwise hold until the running fetch ends
      end
      default: begin
        if (st.need == 8'h00) begin
          next_st.done = 1'b1;
          next_st.ps = DPB_P_IDLE;
        end else if (st.rb_v[idx]) begin
          next_st.rv = 1'b1;
          next_st.rdata = rbuf[idx];
          next_st.need[idx] = 1'b0;
          next_st.rb_v[idx] = 1'b0;
        end
      end
    endcase

    case (st.ms)
      DPB_M_IDLE: begin
        if (st.rfwd) begin
          next_st.sreq = 1'b1;
          next_st.m_rd = 1'b1;
          next_st.ms = DPB_M_REQ;
        end else if (st.wpend && 32'(wf_level) >= 32'(nlw)) begin
          next_st.sreq = 1'b1;
          next_st.m_rd = 1'b0;
          next_st.ms = DPB_M_REQ;
        end
      end
      DPB_M_REQ: begin
        if (sys_gnt_in) begin
          next_st.sreq = 1'b0;
          next_st.mvalid = 1'b1;
          next_st.mlock = st.m_rd && st.l_lock;
          if (st.m_rd) begin
            next_st.mcmd = DPB_MCMD_READ;
            next_st.maddr = {st.l_addr[31:3], 3'b000};
            next_st.mlen = st.f_n;
            next_st.fetch = 1'b1;
            next_st.f_cnt = 3'd0;
            next_st.rfwd = 1'b0;
            next_st.keep = st.keep & blk;
            next_st.ms = DPB_M_IDLE;
          end else begin
            // write widened to quadword or octaword
            next_st.mcmd = DPB_MCMD_WRITE;
            next_st.maddr = {st.w_addr[31:5], wb, 2'b00};
            next_st.mlen = (st.w_len < DPB_LEN_HW) ? DPB_SLEN_QW : DPB_SLEN_OCT;
            next_st.w_slot = 3'd0;
            next_st.ms = DPB_M_WDATA;
          end
        end
      end
      default: begin
        if (!ins || wf_valid) begin
          wf_pop = ins;
          next_st.w_slot = st.w_slot + 3'd1;
          if (!st.w_slot[0]) begin
            next_st.w_lo = d;
            next_st.w_lom = m;
          end else begin
            next_st.mdv = 1'b1;
            next_st.mdata = {d, st.w_lo};
            next_st.mmask = {m, st.w_lom};
          end
          if (st.w_slot == ((st.w_len < DPB_LEN_HW) ? 3'd1 : 3'd3)) begin
            next_st.wpend = 1'b0;
            next_st.ms = DPB_M_IDLE;
          end
        end
      end
    endcase

    // returned quadword marks its kept longwords
    if (filling) begin
      next_st.rb_v = next_st.rb_v | (st.keep & (8'h03 << {fill_q, 1'b0}));
      next_st.f_cnt = st.f_cnt + 3'd1;
      next_st.fetch = (st.f_cnt + 3'd1) != st.f_n;
    end
    // drop prefetch, sparing longwords owed to a running read
    if (inval || (st.ps == DPB_P_CHECK && st.l_lock && !st.l_io)) begin
      next_st.rb_v = next_st.rb_v & ((next_st.ps == DPB_P_SERVE) ? next_st.need : 8'h00);
      next_st.keep = next_st.keep & ((next_st.ps == DPB_P_SERVE) ? next_st.need : 8'h00);
      next_st.prev_v = next_st.prev_v && next_st.rfwd;
    end
    next_st.req_rdy = next_st.ps == DPB_P_IDLE;
  end

  always_ff @(posedge core_clk_in) begin
    // buffer and stored address start invalid
    if (!nrst_in) begin
      st <= '0;
      st.err_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (filling) begin
      rbuf[{fill_q, 1'b0}] <= sys_rdata_in[31:0];
      rbuf[{fill_q, 1'b1}] <= sys_rdata_in[63:32];
    end
  end

  assign sys_req_out = st.sreq;
  assign sys_mvalid_out = st.mvalid;
  assign sys_mcmd_out = st.mcmd;
  assign sys_maddr_out = st.maddr;
  assign sys_mlen_out = st.mlen;
  assign sys_mlock_out = st.mlock;
  assign sys_mdvalid_out = st.mdv;
  assign sys_mdata_out = st.mdata;
  assign sys_mmask_out = st.mmask;
  assign port1_req_ready_out = st.req_rdy;
  assign port1_rvalid_out = st.rv;
  assign port1_rdata_out = st.rdata;
  assign port1_done_out = st.done;
  assign port1_error_n_out = st.err_n;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_ack_match: assert property (
    sys_ack_out |-> $past(sys_cmd_valid_in, 2) && !$past(sys_parity_err_in, 2))
    else $error("ack without a clean request");
  a_io_read_err: assert property (
    st.ps == DPB_P_CHECK && st.l_io |=> !port1_error_n_out && port1_done_out)
    else $error("I/O request not refused");
  a_deliver_clear: assert property (
    port1_rvalid_out |-> (st.rb_v & $past(st.need) & ~st.need) == 8'h00)
    else $error("delivered longword still valid");
  a_forward_inval: assert property (
    $rose(st.rfwd) |-> st.rb_v == 8'h00 && st.ps == DPB_P_SERVE)
    else $error("forward without invalidation");
  a_write_stall: assert property (
    st.ps == DPB_P_CHECK && !st.l_wr && !st.l_io && st.wpend &&
    st.w_addr[31:5] == st.l_addr[31:5] |=> !$rose(st.rfwd) && st.ps == DPB_P_CHECK)
    else $error("read passed matching write");
  a_grant_first: assert property (
    sys_mvalid_out |-> $past(sys_gnt_in) && $past(sys_req_out))
    else $error("address cycle without grant");
  a_write_inval: assert property (
    st.ps == DPB_P_CHECK && st.l_wr && !st.l_io && !st.wpend |=>
    st.rb_v == 8'h00 && !st.prev_v && port1_done_out)
    else $error("write kept prefetch data");
  a_pf_length: assert property (
    sys_mvalid_out && sys_mcmd_out == DPB_MCMD_READ && st.l_len == DPB_LEN_OW &&
    $past(prefetch_en_out) && !sys_mlock_out |-> sys_mlen_out == DPB_SLEN_HEX)
    else $error("octaword read not widened");
  a_reset_clean: assert property (
    $rose(nrst_in) |-> st.rb_v == 8'h00 && !st.prev_v && !st.fetch)
    else $error("buffer valid after reset");

  c_reg_write: cover property (sys_ack_out);
  c_buffer_hit: cover property (st.ps == DPB_P_CHECK ##1 st.ps == DPB_P_SERVE && !st.rfwd);
  c_fetch_done: cover property (st.fetch ##[1:40] port1_done_out);
  c_write_out: cover property (sys_mdvalid_out);

endmodule // dpb_bridge

// ---- tb/dpb_sys_mem.sv ----
/* System bus memory model for the port-1 bridge bench.
   Assumes one core clock and a request held until granted. */
`timescale 1ns/1ps
module dpb_sys_mem
  import dpb_pkg::*;
(
  // Clock, reset and pacing
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] wait_in,
  // From the bridge
  input wire logic sys_req_in,
  input wire logic sys_mvalid_in,
  input wire logic [1:0] sys_mcmd_in,
  input wire logic [31:0] sys_maddr_in,
  input wire logic [2:0] sys_mlen_in,
  // To the bridge
  output logic sys_gnt_out,
  output logic sys_rvalid_out,
  output logic [63:0] sys_rdata_out
);
  int cnt;
  int gap;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] q[$];
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sys_gnt_out <= 1'b0;
      sys_rvalid_out <= 1'b0;
      sys_rdata_out <= 64'h0;
      q.delete();
      cnt = 0;
      gap = 0;
    end else begin
      // Grant after the programmed wait, then hold off while the request drops
      cnt = sys_req_in ? cnt + 1 : 0;
      sys_gnt_out <= (cnt > int'(wait_in));
      if (cnt > int'(wait_in)) cnt = -8;
      if (sys_mvalid_in && sys_mcmd_in == DPB_MCMD_READ) begin
        a = {sys_maddr_in[31:3], 3'h0};
        b = a & ~((32'(sys_mlen_in) << 3) - 32'h1);
        // requested quadword first, wrapping in its block
        for (int i = 0; i < int'(sys_mlen_in); i++)
          q.push_back(b + ((a - b + 32'(i) * 8) % (32'(sys_mlen_in) * 8)));
      end
      // Data lines toggle while no quadword is returned
      sys_rvalid_out <= 1'b0;
      sys_rdata_out <= ~sys_rdata_out;
      gap = (q.size() > 0) ? gap + 1 : 0;
      if (gap > int'(wait_in)) begin
        sys_rvalid_out <= 1'b1;
        sys_rdata_out <= {q[0] ^ 32'h5a5a_0004, q[0] ^ 32'h5a5a_0000};
        void'(q.pop_front());
        gap = 0;
      end
    end
  end
endmodule // dpb_sys_mem

// ---- tb/test_dma_port_bridge_prefetch.sv ----
/* Self-checking bench of the port-1 DMA bridge with a memory model.
   Assumes the 20 MHz core clock and the default write buffer depth. */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module test_dma_port_bridge_prefetch;
  import dpb_pkg::*;
  typedef struct packed {logic pf; logic io; logic [1:0] len; logic [31:0] ad; logic [2:0] ml;} dpb_row_s;
  dpb_row_s rows [12] = '{'{1'h1,1'h0,DPB_LEN_LW,32'h1000,3'h1}, '{1'h1,1'h0,DPB_LEN_LW,32'h1004,3'h0},
    '{1'h1,1'h0,DPB_LEN_LW,32'h1004,3'h1}, '{1'h1,1'h0,DPB_LEN_QW,32'h1008,3'h2},
    '{1'h1,1'h0,DPB_LEN_LW,32'h1004,3'h0}, '{1'h1,1'h0,DPB_LEN_OW,32'h1010,3'h4},
    '{1'h1,1'h0,DPB_LEN_QW,32'h1008,3'h0}, '{1'h1,1'h0,DPB_LEN_HW,32'h2000,3'h2},
    '{1'h1,1'h0,DPB_LEN_LW,32'h200c,3'h0}, '{1'h0,1'h0,DPB_LEN_LW,32'h3000,3'h1},
    '{1'h0,1'h0,DPB_LEN_LW,32'h3004,3'h1}, '{1'h1,1'h1,DPB_LEN_LW,32'h4000,3'h0}};
  logic core_clk_in = 0, nrst_in = 0, sys_cmd_valid_in = 0, sys_parity_err_in = 0;
  logic [2:0] sys_cmd_in = 0;
  logic [31:0] sys_addr_in = 0, port1_addr_in = 0, port1_wdata_in = 0, ma, sys_maddr_out;
  logic [7:0] sys_mask_in = 0, sys_mmask_out, wmk;
  logic [63:0] sys_data_in = 0, sys_rdata_in, sys_mdata_out, wdq;
  logic port1_req_valid_in = 0, port1_req_write_in = 0, port1_req_lock_in = 0, port1_req_io_in = 0;
  logic port1_io_txn_in = 0, port1_wvalid_in = 0, sys_gnt_in, sys_rvalid_in, err_n, lk;
  logic [1:0] port1_len_in = 0, sys_mcmd_out;
  logic [3:0] port1_wmask_in = 4'hf, wt = 4'h0;
  logic [2:0] sys_mlen_out, ml;
  logic sys_ack_out, prefetch_en_out, sys_req_out, sys_mvalid_out, sys_mlock_out, sys_mdvalid_out;
  logic port1_req_ready_out, port1_wready_out, port1_rvalid_out, port1_done_out, port1_error_n_out;
  logic [31:0] port1_rdata_out;
  logic [31:0] got[$];
  logic [1:0] cmds[$];
  int error_cnt = 0, samples_checked = 0, cyc = 0, rd = 0, md = 0, n, k;
  always #25 core_clk_in = ~core_clk_in;
  dpb_bridge u_dpb_bridge (.core_clk_in, .nrst_in, .sys_cmd_valid_in, .sys_cmd_in, .sys_addr_in,
    .sys_mask_in, .sys_data_in, .sys_parity_err_in, .sys_ack_out, .prefetch_en_out, .sys_req_out,
    .sys_gnt_in, .sys_mvalid_out, .sys_mcmd_out, .sys_maddr_out, .sys_mlen_out, .sys_mlock_out,
    .sys_mdvalid_out, .sys_mdata_out, .sys_mmask_out, .sys_rvalid_in, .sys_rdata_in,
    .port1_req_valid_in, .port1_req_ready_out, .port1_req_write_in, .port1_req_lock_in,
    .port1_req_io_in, .port1_addr_in, .port1_len_in, .port1_io_txn_in, .port1_wvalid_in,
    .port1_wready_out, .port1_wdata_in, .port1_wmask_in, .port1_rvalid_out, .port1_rdata_out,
    .port1_done_out, .port1_error_n_out);
  dpb_sys_mem u_dpb_sys_mem (.core_clk_in, .nrst_in, .wait_in(wt), .sys_req_in(sys_req_out),
    .sys_mvalid_in(sys_mvalid_out), .sys_mcmd_in(sys_mcmd_out), .sys_maddr_in(sys_maddr_out),
    .sys_mlen_in(sys_mlen_out), .sys_gnt_out(sys_gnt_in), .sys_rvalid_out(sys_rvalid_in),
    .sys_rdata_out(sys_rdata_in));
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watch the system bus and cut a hang short
  always @(posedge core_clk_in) begin
    if (sys_mvalid_out === 1'b1) begin
      cmds.push_back(sys_mcmd_out); ml = sys_mlen_out; lk = sys_mlock_out; ma = sys_maddr_out;
      rd += int'(sys_mcmd_out === DPB_MCMD_READ);
    end
    if (sys_mdvalid_out === 1'b1) begin md++; wdq = sys_mdata_out; wmk = sys_mmask_out; end
    cyc++;
    if (cyc == 20000) begin error_cnt++; test_done(); end
  end
  task automatic reg_wr(input logic [31:0] a, input logic [2:0] c, input logic [7:0] m,
      input logic [63:0] d, input logic p, input int ea, input logic ep);
    int acks = 0;
    @(posedge core_clk_in); #1;
    {sys_cmd_valid_in, sys_cmd_in, sys_addr_in, sys_mask_in, sys_data_in, sys_parity_err_in} = {1'b1, c, a, m, d, p};
    @(posedge core_clk_in); #1 sys_cmd_valid_in = 0;
    repeat (4) begin @(posedge core_clk_in); acks += int'(sys_ack_out === 1'b1); end
    `CHK(acks, ea)
    `CHK(prefetch_en_out, ep)
  endtask
  task automatic port(input logic w, lo, io, input logic [31:0] a, input logic [1:0] l);
    got.delete();
    @(posedge core_clk_in); #1;
    {port1_req_valid_in, port1_req_write_in, port1_req_lock_in, port1_req_io_in} = {1'b1, w, lo, io};
    {port1_addr_in, port1_len_in} = {a, l};
    do @(posedge core_clk_in); while (port1_req_ready_out !== 1'b1);
    #1 port1_req_valid_in = 0;
    k = 0;
    do begin
      @(posedge core_clk_in); k++;
      if (port1_rvalid_out === 1'b1) got.push_back(port1_rdata_out);
    end while (port1_done_out !== 1'b1 && k < 300);
    err_n = port1_error_n_out;
    `CHK(port1_done_out, 1'b1)
  endtask
  task automatic wd(input logic [31:0] d);
    @(posedge core_clk_in); #1 {port1_wvalid_in, port1_wdata_in} = {1'b1, d};
    do @(posedge core_clk_in); while (port1_wready_out !== 1'b1);
    #1 port1_wvalid_in = 0;
  endtask
  task automatic drain(input int t);
    for (int i = 0; i < 300 && md < t; i++) @(posedge core_clk_in);
    `CHK(md, t)
  endtask
  initial begin
    repeat (2) @(posedge core_clk_in);
    `CHK({port1_req_ready_out, port1_error_n_out, prefetch_en_out}, 3'b010)
    #1 nrst_in = 1;
    reg_wr(DPB_REG_BASE, DPB_CMD_WRITE, 8'h0f, 64'h1, 0, 1, 1);
    reg_wr(DPB_REG_BASE, DPB_CMD_WRITE_DISOWN, 8'h00, 64'h0, 0, 1, 1);
    reg_wr(DPB_REG_BASE + 32'h8, DPB_CMD_WRITE, 8'h0f, 64'h0, 0, 0, 1);
    reg_wr(DPB_REG_BASE, DPB_CMD_WRITE, 8'h0f, 64'h0, 1, 0, 1);
    reg_wr(DPB_REG_BASE, 3'h0, 8'h0f, 64'h0, 0, 0, 1);
    foreach (rows[r]) begin
      if (rows[r].pf !== prefetch_en_out) reg_wr(DPB_REG_BASE, DPB_CMD_WRITE_DISOWN, 8'hff,
        64'(rows[r].pf), 0, 1, rows[r].pf);
      n = rd;
      port(0, 0, rows[r].io, rows[r].ad, rows[r].len);
      `CHK(err_n, !rows[r].io)
      `CHK(rd - n, int'(rows[r].ml != 0))
      if (rows[r].ml != 0) `CHK(ml, rows[r].ml)
      `CHK(got.size(), rows[r].io ? 0 : int'(rows[r].len) + 1)
      foreach (got[i]) `CHK(got[i], (rows[r].ad + 32'(4 * i)) ^ 32'h5a5a_0000)
    end
    for (int v = 0; v < 3; v++) begin
      port(0, 0, 0, 32'h1000, DPB_LEN_QW);
      if (v == 0) begin
        wd(32'hcafe_0001); port(1, 0, 0, 32'h5004, DPB_LEN_LW); drain(1);
        `CHK({ma, ml, wmk, wdq[63:32]}, {32'h5000, DPB_SLEN_QW, 8'hf0, 32'hcafe_0001})
      end
      if (v == 1) begin @(posedge core_clk_in); #1 port1_io_txn_in = 1;
        @(posedge core_clk_in); #1 port1_io_txn_in = 0; end
      n = rd;
      port(0, v == 2, 0, 32'h1008, DPB_LEN_LW);
      `CHK(rd - n, 1)
    end
    `CHK(lk, 1'b1)
    port(1, 0, 1, 32'h6000, DPB_LEN_LW);
    `CHK(err_n, 1'b0)
    wt = 4'h6;
    port(1, 0, 0, 32'h7000, DPB_LEN_LW);
    fork port(0, 0, 0, 32'h7004, DPB_LEN_LW);
      begin repeat (4) @(posedge core_clk_in); wd(32'h1234_5678); end join
    `CHK({cmds[$-1], cmds[$]}, {DPB_MCMD_WRITE, DPB_MCMD_READ})
    // Fill the write buffer until it refuses, then drain it with a slow bus
    wt = 4'h3; n = 0; k = md;
    @(posedge core_clk_in); #1 port1_wvalid_in = 1;
    repeat (40) begin @(posedge core_clk_in); n += int'(port1_wready_out === 1'b1); end
    #1 port1_wvalid_in = 0;
    `CHK(n, int'(DPB_WBUF_DEPTH))
    n = k;
    repeat (8) port(1, 0, 0, 32'h8000, DPB_LEN_OW);
    drain(n + 16);
    `CHK({ml, port1_wready_out}, {DPB_SLEN_OCT, 1'b1})
    test_done();
  end
endmodule // test_dma_port_bridge_prefetch
